// >>> src/dtt_thermal_pin_logic.sv
`default_nettype none

module dtt_thermal_pin_logic #(
  parameter int unsigned NUM_RANKS = 8   // Ranks on the channel
) (
  input  wire logic                                     ref_clk_in,             // 40 MHz controller clock
  input  wire logic                                     rst_b_in,               // Async reset, active low
  input  wire dtt_pkg::dtt_cfg_req_t                    cfg_req_in,             // Config space request
  output logic [dtt_pkg::DATA_W-1:0]                    cfg_rdata_out,          // Read data, registered
  output logic                                          cfg_rvalid_out,         // Read data valid pulse
  input  wire logic                                     external_thermal_event_pin_b_in, // Thermal pin, low active
  input  wire logic [dtt_pkg::RANK_SLOTS-1:0][dtt_pkg::VT_W-1:0] rank_vt_in,   // Virtual temperature per slot
  input  wire dtt_pkg::dtt_mode_t                       throttle_mode_in,       // Channel throttle mode
  input  wire logic [dtt_pkg::RANK_SLOTS-1:0]           throttle_now_in,        // Direct throttle vector
  input  wire logic [dtt_pkg::RATIO_W-1:0]              max_ratio_in,           // Part ratio limit
  input  wire logic [dtt_pkg::RATIO_W-1:0]              requested_memory_clock_ratio_in, // Requested data ratio
  output logic [NUM_RANKS-1:0]                          rank_throttle_out,      // Throttle per rank
  output logic [dtt_pkg::RATIO_W-1:0]                   module_clock_ratio_out  // Ratio of module clock
);

  // ==========================================================================
  // Reset release
  logic rst_meta_b;
  logic rst_sync_b;

  // Assert at once, release after two clean edges
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ==========================================================================
  // Address decode
  wire hit_ratio  = cfg_req_in.addr == dtt_pkg::OFS_RATIO_STATUS;
  wire hit_offset = cfg_req_in.addr == dtt_pkg::OFS_THROTTLE_OFS;
  wire hit_vtemp  = cfg_req_in.addr == dtt_pkg::OFS_VIRTUAL_TEMP;
  wire hit_cmd    = cfg_req_in.addr == dtt_pkg::OFS_PIN_COMMAND;
  wire hit_status = cfg_req_in.addr == dtt_pkg::OFS_PIN_STATUS;
  wire wr_offset  = cfg_req_in.wr & hit_offset;
  wire wr_cmd     = cfg_req_in.wr & hit_cmd;
  wire wr_status  = cfg_req_in.wr & hit_status;

  // ==========================================================================
  // Pin synchroniser and edge detect
  logic pin_level;
  logic pin_assert_edge;
  logic pin_release_edge;

  dtt_pin_sync u_pin_sync (
    .clk_in           (ref_clk_in),
    .rst_b_in         (rst_sync_b),
    .pin_b_in         (external_thermal_event_pin_b_in),
    .level_out        (pin_level),
    .assert_edge_out  (pin_assert_edge),
    .release_edge_out (pin_release_edge)
  );

  // ==========================================================================
  // Command register
  dtt_pkg::dtt_cmd_t cmd;
  dtt_pkg::dtt_cmd_t next_cmd;

  // Once locked every field, lock included, holds until reset
  always_comb begin
    next_cmd = cmd;
    if (wr_cmd && !cmd.lock) begin
      next_cmd.force_throttle     = cfg_req_in.wdata[dtt_pkg::CMD_FORCE_BIT];
      next_cmd.spare              = cfg_req_in.wdata[dtt_pkg::CMD_SPARE_BIT];
      next_cmd.ignore_thermal_pin = cfg_req_in.wdata[dtt_pkg::CMD_IGNORE_BIT];
      next_cmd.lock               = cfg_req_in.wdata[dtt_pkg::CMD_LOCK_BIT];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cmd <= '0;
    end else begin
      cmd <= next_cmd;
    end
  end

  // ==========================================================================
  // Edge status flags
  logic assert_seen;
  logic pin_release_edge_seen;

  // Ignoring the pin also blocks new edges, which freezes both flags
  wire take_edges     = ~cmd.ignore_thermal_pin;
  wire clr_assert     = wr_status & cfg_req_in.wdata[dtt_pkg::STS_ASSERT_BIT];
  wire clr_release    = wr_status & cfg_req_in.wdata[dtt_pkg::STS_RELEASE_BIT];
  // A clear is also suppressed while frozen, so the flags truly hold
  wire next_assert_seen  = (take_edges & pin_assert_edge) |
                           (assert_seen & ~(clr_assert & take_edges));
  wire next_release_seen = (take_edges & pin_release_edge) |
                           (pin_release_edge_seen & ~(clr_release & take_edges));

  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      assert_seen           <= 1'b0;
      pin_release_edge_seen <= 1'b0;
    end else begin
      assert_seen           <= next_assert_seen;
      pin_release_edge_seen <= next_release_seen;
    end
  end

  // ==========================================================================
  // Per-slot offsets, reported temperature and throttle decision
  logic [dtt_pkg::RANK_SLOTS-1:0][dtt_pkg::RANK_FIELD_W-1:0] rank_offset;
  logic [dtt_pkg::RANK_SLOTS-1:0][dtt_pkg::RANK_FIELD_W-1:0] rank_vt_report;
  logic [dtt_pkg::RANK_SLOTS-1:0]                            slot_over;
  logic [dtt_pkg::RANK_SLOTS-1:0]                            slot_throttle;

  // Pin throttling needs the force bit, the pin, and the response enabled
  wire pin_throttle = cmd.force_throttle & pin_level & ~cmd.ignore_thermal_pin;

  genvar s;
  generate
    for (s = 0; s < dtt_pkg::RANK_SLOTS; s++) begin : g_slot
      // Offset byte s sits at bits 8s+7:8s, rank 3 in the top byte
      always_ff @(posedge ref_clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          rank_offset[s] <= dtt_pkg::OFFSET_RESET;
        end else if (wr_offset) begin
          rank_offset[s] <= cfg_req_in.wdata[s*dtt_pkg::RANK_FIELD_W +: dtt_pkg::RANK_FIELD_W];
        end
      end

      // Report the top byte, one bit above the compared window
      always_ff @(posedge ref_clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          rank_vt_report[s] <= dtt_pkg::VT_RESET;
        end else begin
          rank_vt_report[s] <= rank_vt_in[s][dtt_pkg::VT_RPT_LO +: dtt_pkg::RANK_FIELD_W];
        end
      end

      // Strictly greater, so an offset of all ones never trips open loop
      assign slot_over[s] = rank_vt_in[s][dtt_pkg::VT_CMP_LO +: dtt_pkg::RANK_FIELD_W] >
                            rank_offset[s];

      // Mode selects the throttle source for this slot
      always_comb begin
        unique case (throttle_mode_in)
          dtt_pkg::DTT_MODE_OFF:       slot_throttle[s] = pin_throttle;
          dtt_pkg::DTT_MODE_OPEN_LOOP: slot_throttle[s] = slot_over[s] | pin_throttle;
          dtt_pkg::DTT_MODE_DIRECT:    slot_throttle[s] = throttle_now_in[s] | pin_throttle;
          dtt_pkg::DTT_MODE_PIN:       slot_throttle[s] = pin_throttle | slot_over[s];
        endcase
      end
    end
  endgenerate

  // ==========================================================================
  // Rank fan-out: ranks beyond four reuse slot r mod 4
  logic [NUM_RANKS-1:0] rank_throttle;

  genvar r;
  generate
    for (r = 0; r < NUM_RANKS; r++) begin : g_rank
      always_ff @(posedge ref_clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          rank_throttle[r] <= 1'b0;
        end else begin
          rank_throttle[r] <= slot_throttle[r % dtt_pkg::RANK_SLOTS];
        end
      end
    end
  endgenerate

  assign rank_throttle_out = rank_throttle;

  // ==========================================================================
  // Clock ratio status
  logic [dtt_pkg::RATIO_W-1:0] ratio_max;
  logic [dtt_pkg::RATIO_W-1:0] ratio_cur;
  logic [dtt_pkg::RATIO_W-1:0] module_ratio;

  // Module clock toggles once per two data beats, hence the halved ratio
  always_ff @(posedge ref_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ratio_max    <= dtt_pkg::RATIO_RESERVED;
      ratio_cur    <= dtt_pkg::RATIO_RESERVED;
      module_ratio <= dtt_pkg::RATIO_RESERVED;
    end else begin
      ratio_max    <= max_ratio_in;
      ratio_cur    <= requested_memory_clock_ratio_in;
      module_ratio <= requested_memory_clock_ratio_in >> 1;
    end
  end

  assign module_clock_ratio_out = module_ratio;

  // ==========================================================================
  // Read data assembly
  logic [dtt_pkg::DATA_W-1:0] ratio_word;
  logic [dtt_pkg::DATA_W-1:0] cmd_word;
  logic [dtt_pkg::DATA_W-1:0] status_word;
  logic [dtt_pkg::DATA_W-1:0] read_word;

  // Unused bits read as zero
  always_comb begin
    ratio_word = dtt_pkg::READ_ZERO;
    ratio_word[dtt_pkg::RATIO_MAX_LSB +: dtt_pkg::RATIO_W] = ratio_max;
    ratio_word[dtt_pkg::RATIO_CUR_LSB +: dtt_pkg::RATIO_W] = ratio_cur;
    cmd_word = dtt_pkg::READ_ZERO;
    cmd_word[dtt_pkg::CMD_FORCE_BIT]  = cmd.force_throttle;
    cmd_word[dtt_pkg::CMD_SPARE_BIT]  = cmd.spare;
    cmd_word[dtt_pkg::CMD_IGNORE_BIT] = cmd.ignore_thermal_pin;
    cmd_word[dtt_pkg::CMD_LOCK_BIT]   = cmd.lock;
    status_word = dtt_pkg::READ_ZERO;
    status_word[dtt_pkg::STS_ASSERT_BIT]  = assert_seen;
    status_word[dtt_pkg::STS_RELEASE_BIT] = pin_release_edge_seen;
    status_word[dtt_pkg::STS_LEVEL_BIT]   = pin_level;
  end

  // Unmapped offsets answer zero rather than stalling the access
  assign read_word = hit_ratio  ? ratio_word :
                     hit_offset ? rank_offset :
                     hit_vtemp  ? rank_vt_report :
                     hit_cmd    ? cmd_word :
                     hit_status ? status_word : dtt_pkg::READ_ZERO;

  // Read answer one cycle after the request
  always_ff @(posedge ref_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cfg_rdata_out  <= dtt_pkg::READ_ZERO;
      cfg_rvalid_out <= 1'b0;
    end else begin
      cfg_rdata_out  <= cfg_req_in.rd ? read_word : cfg_rdata_out;
      cfg_rvalid_out <= cfg_req_in.rd;
    end
  end

endmodule : dtt_thermal_pin_logic

`default_nettype wire

// >>> src/dtt_pkg.sv
// Functional notes
// - Each rank compares its 8-bit offset against virtual temperature bits 36:29.
// - More than four ranks share the four per-rank throttle slots.
// - Offset register holds four RW bytes, rank 3 high, rank 0 low, reset zero.
// - Read-only register shows virtual temperature bits 37:30 per rank, reset zero.
// - Reported temperature sits one bit right of the offset scale.
// - Force bit set: throttle while the thermal pin is asserted.
// - Ignore bit set: pin response off, edge flags frozen.
// - Lock bit is write-one-to-set; locks whole command register until reset.
// - Status bit 2 sets on pin assertion edge, write one clears.
// - Status bit 1 sets on pin release edge, write one clears.
// - Status bit 0 shows synchronised pin level, 1 when asserted.
// - Ratio status bits 28:24 report maximum ratio: 06, 08, 0A; 00 reserved.
// - Ratio status bits 4:0 report the current ratio, same encoding.
// - Module clock runs at half the requested data rate.
// - Mode 1 throttles a rank when its temperature exceeds its offset.
// - Mode 3 throttles when force bit set and pin asserted, or when a rank's temperature exceeds its offset.
`default_nettype none

package dtt_pkg;

  // ==========================================================================
  // Register map
  localparam int unsigned      ADDR_W             = 8;
  localparam int unsigned      DATA_W             = 32;
  localparam logic [7:0]       OFS_RATIO_STATUS   = 8'h50;
  localparam logic [7:0]       OFS_THROTTLE_OFS   = 8'h88;
  localparam logic [7:0]       OFS_VIRTUAL_TEMP   = 8'h98;
  localparam logic [7:0]       OFS_PIN_COMMAND    = 8'h9C;
  localparam logic [7:0]       OFS_PIN_STATUS     = 8'hA4;
  localparam logic [31:0]      READ_ZERO          = 32'h0000_0000;

  // ==========================================================================
  // Per-rank fields
  localparam int unsigned      RANK_SLOTS         = 4;
  localparam int unsigned      RANK_FIELD_W       = 8;
  localparam int unsigned      VT_W               = 38;
  localparam int unsigned      VT_CMP_LO          = 29;
  localparam int unsigned      VT_RPT_LO          = 30;
  localparam logic [7:0]       OFFSET_RESET       = 8'h00;
  localparam logic [7:0]       OFFSET_SUGGESTED   = 8'hFF;
  localparam logic [7:0]       VT_RESET           = 8'h00;

  // ==========================================================================
  // Command and status bits
  localparam int unsigned      CMD_LOCK_BIT       = 0;
  localparam int unsigned      CMD_IGNORE_BIT     = 1;
  localparam int unsigned      CMD_SPARE_BIT      = 2;
  localparam int unsigned      CMD_FORCE_BIT      = 3;
  localparam int unsigned      STS_LEVEL_BIT      = 0;
  localparam int unsigned      STS_RELEASE_BIT    = 1;
  localparam int unsigned      STS_ASSERT_BIT     = 2;

  // ==========================================================================
  // Clock ratio fields and encodings
  localparam int unsigned      RATIO_W            = 5;
  localparam int unsigned      RATIO_MAX_LSB      = 24;
  localparam int unsigned      RATIO_CUR_LSB      = 0;
  localparam logic [4:0]       RATIO_RESERVED     = 5'h00;
  localparam logic [4:0]       RATIO_800          = 5'h06;
  localparam logic [4:0]       RATIO_1066         = 5'h08;
  localparam logic [4:0]       RATIO_1333         = 5'h0A;

  // Throttle modes chosen by the channel thermal control
  typedef enum logic [1:0] {
    DTT_MODE_OFF        = 2'b00,
    DTT_MODE_OPEN_LOOP  = 2'b01,
    DTT_MODE_DIRECT     = 2'b10,
    DTT_MODE_PIN        = 2'b11
  } dtt_mode_t;

  // Configuration space access, one dword per request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [7:0]        addr;
    logic [31:0]       wdata;
  } dtt_cfg_req_t;

  // Command register contents
  typedef struct packed {
    logic force_throttle;
    logic spare;
    logic ignore_thermal_pin;
    logic lock;
  } dtt_cmd_t;

endpackage : dtt_pkg

`default_nettype wire

// >>> src/dtt_pin_sync.sv
`default_nettype none

module dtt_pin_sync (
  input  wire logic clk_in,             // Controller clock
  input  wire logic rst_b_in,           // Synchronised reset, active low
  input  wire logic pin_b_in,           // Thermal pin, active low, asynchronous
  output logic      level_out,          // Synchronised level, 1 when asserted
  output logic      assert_edge_out,    // One-cycle pulse on assertion
  output logic      release_edge_out    // One-cycle pulse on release
);

  // ==========================================================================
  // Synchroniser
  logic meta_b;
  logic sync_b;
  logic last_b;

  // The pin idles high, so the flops reset to the released level
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_b <= 1'b1;
      sync_b <= 1'b1;
      last_b <= 1'b1;
    end else begin
      meta_b <= pin_b_in;
      sync_b <= meta_b;
      last_b <= sync_b;
    end
  end

  // Edges come from the settled copy only, so a glitch cannot double-set
  assign level_out        = ~sync_b;
  assign assert_edge_out  = last_b & ~sync_b;
  assign release_edge_out = ~last_b & sync_b;

endmodule : dtt_pin_sync

`default_nettype wire

// >>> verification/dtt_checker.sv
`default_nettype none

module dtt_checker #(
  parameter int unsigned NUM_RANKS = 8  // Ranks on the channel
) (
  input  wire logic                                              ref_clk_in,                       // Clock
  input  wire logic                                              rst_b_in,                         // Reset, low
  input  wire dtt_pkg::dtt_cfg_req_t                             cfg_req_in,                       // Request
  input  wire logic [dtt_pkg::DATA_W-1:0]                        cfg_rdata_out,                    // Read data
  input  wire logic                                              cfg_rvalid_out,                   // Read valid
  input  wire logic                                              external_thermal_event_pin_b_in,  // Pin
  input  wire logic [dtt_pkg::RANK_SLOTS-1:0][dtt_pkg::VT_W-1:0] rank_vt_in,                       // Temps
  input  wire dtt_pkg::dtt_mode_t                                throttle_mode_in,                 // Mode
  input  wire logic [dtt_pkg::RANK_SLOTS-1:0]                    throttle_now_in,                  // Direct
  input  wire logic [dtt_pkg::RATIO_W-1:0]                       max_ratio_in,                     // Max ratio
  input  wire logic [dtt_pkg::RATIO_W-1:0]                       requested_memory_clock_ratio_in,  // Request
  input  wire logic [NUM_RANKS-1:0]                              rank_throttle_out,                // Throttle
  input  wire logic [dtt_pkg::RATIO_W-1:0]                       module_clock_ratio_out            // Module clk
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Helpers: the design's own reset lags the pin by two flops, so wait it out
  logic [1:0]           up_cnt;
  wire logic            up = (up_cnt == 2'h3);
  wire logic            pin_b = external_thermal_event_pin_b_in;
  wire logic [31:0]     exp_vt;
  wire logic [NUM_RANKS-1:0] exp_direct;
  wire logic            mapped = cfg_req_in.addr inside {8'h50, 8'h88, 8'h98, 8'h9C, 8'hA4};

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) up_cnt <= 2'h0;
    else if (!up) up_cnt <= up_cnt + 2'h1;
  end

  // Expected read image and slot sharing
  for (genvar i = 0; i < 4; i++) begin : g_vt
    assign exp_vt[8*i+:8] = rank_vt_in[i][37:30];
  end
  for (genvar r = 0; r < NUM_RANKS; r++) begin : g_rk
    assign exp_direct[r] = throttle_now_in[r%4];
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  // ==========================================================================
  // Sequences and properties
  sequence s_rd(logic [7:0] a);
    up && cfg_req_in.rd && cfg_req_in.addr == a;
  endsequence
  sequence s_cool;
    pin_b [*5];
  endsequence

  property p_rvalid;
    up |-> cfg_rvalid_out == $past(cfg_req_in.rd);
  endproperty
  property p_unmapped;
    up && cfg_req_in.rd && !mapped |=> cfg_rdata_out == 32'h0000_0000;
  endproperty
  property p_vt_read;
    s_rd(8'h98) ##0 $stable(rank_vt_in) |=> cfg_rdata_out == $past(exp_vt);
  endproperty
  property p_ratio_read;
    s_rd(8'h50) ##0 ($stable(max_ratio_in) && $stable(requested_memory_clock_ratio_in))
      |=> cfg_rdata_out == {3'h0, $past(max_ratio_in), 19'h0, $past(requested_memory_clock_ratio_in)};
  endproperty
  property p_modclk;
    up |-> module_clock_ratio_out == ($past(requested_memory_clock_ratio_in) >> 1);
  endproperty
  property p_direct;
    s_cool ##0 (up && $past(throttle_mode_in) == dtt_pkg::DTT_MODE_DIRECT)
      |-> rank_throttle_out == $past(exp_direct);
  endproperty
  property p_off;
    s_cool ##0 (up && $past(throttle_mode_in) == dtt_pkg::DTT_MODE_OFF) |-> rank_throttle_out == '0;
  endproperty
  property p_level;
    ($stable(pin_b) [*4]) ##0 s_rd(8'hA4) |=> cfg_rdata_out[0] == !$past(pin_b);
  endproperty

  a_rvalid:     assert property (p_rvalid) else $error("read valid not one cycle after read");
  a_unmapped:   assert property (p_unmapped) else $error("unmapped read not zero");
  a_vt_read:    assert property (p_vt_read) else $error("temperature read wrong");
  a_ratio_read: assert property (p_ratio_read) else $error("ratio read wrong");
  a_modclk:     assert property (p_modclk) else $error("module clock ratio wrong");
  a_direct:     assert property (p_direct) else $error("direct throttle wrong");
  a_off:        assert property (p_off) else $error("throttle without cause");
  a_level:      assert property (p_level) else $error("pin level bit wrong");
endmodule : dtt_checker

bind dtt_thermal_pin_logic dtt_checker #(.NUM_RANKS(NUM_RANKS)) i_chk (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .cfg_req_in(cfg_req_in), .cfg_rdata_out(cfg_rdata_out),
  .cfg_rvalid_out(cfg_rvalid_out), .external_thermal_event_pin_b_in(external_thermal_event_pin_b_in),
  .rank_vt_in(rank_vt_in), .throttle_mode_in(throttle_mode_in), .throttle_now_in(throttle_now_in),
  .max_ratio_in(max_ratio_in), .requested_memory_clock_ratio_in(requested_memory_clock_ratio_in),
  .rank_throttle_out(rank_throttle_out), .module_clock_ratio_out(module_clock_ratio_out));

`default_nettype wire

// >>> verification/dtt_sensor_model.sv
`default_nettype none

module dtt_sensor_model (
  input  wire logic clk_in,     // Controller clock
  output var  logic pin_b_out   // Thermal event, low when hot
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Open-drain line with pull-up: released reads high
  initial pin_b_out = 1'b1;

  // Level changes only just after an edge, never on it
  task automatic drive(input logic hot);
    @(posedge clk_in);
    #2 pin_b_out = ~hot;
  endtask : drive
endmodule : dtt_sensor_model

`default_nettype wire

// >>> verification/dtt_testbench.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Stimulus and observed signals
  logic                  clk = 1'b0;
  logic                  rst_b = 1'b0;
  dtt_pkg::dtt_cfg_req_t req = '0;
  logic [31:0]           rdata;
  logic                  rvalid;
  wire logic             pin_b;
  logic [3:0][37:0]      vt = '0;
  dtt_pkg::dtt_mode_t    mode = dtt_pkg::DTT_MODE_OFF;
  logic [3:0]            now = 4'h0;
  logic [4:0]            max_r = 5'h00;
  logic [4:0]            req_r = 5'h00;
  logic [7:0]            thr;
  logic [4:0]            mclk;
  int                    errors = 0;
  int                    n_tests = 0;

  always #12.5 clk = ~clk;

  dtt_thermal_pin_logic #(.NUM_RANKS(8)) i_dut (
    .ref_clk_in(clk), .rst_b_in(rst_b), .cfg_req_in(req), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid),
    .external_thermal_event_pin_b_in(pin_b), .rank_vt_in(vt), .throttle_mode_in(mode),
    .throttle_now_in(now), .max_ratio_in(max_r), .requested_memory_clock_ratio_in(req_r),
    .rank_throttle_out(thr), .module_clock_ratio_out(mclk));
  dtt_sensor_model i_sensor (.clk_in(clk), .pin_b_out(pin_b));

  // ==========================================================================
  // Shared tasks; each access takes two cycles so no strobe is set twice at once
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : wait_cyc

  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    wait_cyc(1);
    req = '0;
    wait_cyc(1);
  endtask : cfg_wr

  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    wait_cyc(1);
    req = '0;
    check("rvalid", 32'h0000_0001, {31'h0, rvalid});
    check(what, exp, rdata);
    wait_cyc(1);
  endtask : cfg_rd

  task automatic do_reset;
    rst_b = 1'b0;
    wait_cyc(12);
    rst_b = 1'b1;
    wait_cyc(3);
  endtask : do_reset

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    cfg_rd(8'h88, 32'h0000_0000, "offsets");
    cfg_rd(8'h9C, 32'h0000_0000, "command");
    cfg_rd(8'hA4, 32'h0000_0000, "status");
    $display("test reset done");
  endtask : t_reset

  task automatic t_throttle;
    logic [31:0] cmp;
    cmp = 32'h4011_FF01;
    for (int i = 0; i < 4; i++) vt[i] = {1'b0, cmp[8*i+:8], 29'h0};
    cfg_wr(8'h88, 32'h4010_FF00);
    cfg_rd(8'h88, 32'h4010_FF00, "offsets");
    cfg_rd(8'h98, 32'h2008_7F00, "temps");
    cfg_wr(8'h98, 32'hFFFF_FFFF);
    cfg_rd(8'h98, 32'h2008_7F00, "temps ro");
    cfg_rd(8'hF0, 32'h0000_0000, "unmapped");
    mode = dtt_pkg::DTT_MODE_OPEN_LOOP;
    wait_cyc(2);
    check("open loop", 32'h55, {24'h0, thr});
    mode = dtt_pkg::DTT_MODE_PIN;
    wait_cyc(2);
    check("pin mode", 32'h55, {24'h0, thr});
    mode = dtt_pkg::DTT_MODE_DIRECT;
    now = 4'hA;
    wait_cyc(2);
    check("direct", 32'hAA, {24'h0, thr});
    mode = dtt_pkg::DTT_MODE_OFF;
    wait_cyc(2);
    check("off", 32'h00, {24'h0, thr});
    // All-ones offsets never trip open loop, since the compare is strict
    cfg_wr(8'h88, 32'hFFFF_FFFF);
    mode = dtt_pkg::DTT_MODE_OPEN_LOOP;
    wait_cyc(2);
    check("offset 255", 32'h00, {24'h0, thr});
    mode = dtt_pkg::DTT_MODE_OFF;
    $display("test throttle done");
  endtask : t_throttle

  task automatic t_pin;
    cfg_wr(8'h9C, 32'h0000_0008);
    cfg_rd(8'h9C, 32'h0000_0008, "command");
    i_sensor.drive(1'b1);
    wait_cyc(4);
    cfg_rd(8'hA4, 32'h0000_0005, "status hot");
    check("forced", 32'hFF, {24'h0, thr});
    i_sensor.drive(1'b0);
    wait_cyc(4);
    cfg_rd(8'hA4, 32'h0000_0006, "status cool");
    check("released", 32'h00, {24'h0, thr});
    cfg_wr(8'hA4, 32'h0000_0000);
    cfg_rd(8'hA4, 32'h0000_0006, "w0 keeps");
    cfg_wr(8'hA4, 32'h0000_0004);
    cfg_rd(8'hA4, 32'h0000_0002, "w1c assert");
    cfg_wr(8'hA4, 32'h0000_0002);
    cfg_rd(8'hA4, 32'h0000_0000, "w1c release");
    $display("test pin done");
  endtask : t_pin

  task automatic t_ignore;
    cfg_wr(8'h9C, 32'h0000_000E);
    cfg_rd(8'h9C, 32'h0000_000E, "command ignore");
    i_sensor.drive(1'b1);
    wait_cyc(4);
    cfg_rd(8'hA4, 32'h0000_0001, "frozen hot");
    check("ignored", 32'h00, {24'h0, thr});
    i_sensor.drive(1'b0);
    wait_cyc(4);
    cfg_rd(8'hA4, 32'h0000_0000, "frozen cool");
    $display("test ignore done");
  endtask : t_ignore

  task automatic t_ratio;
    logic [4:0] enc [3];
    enc = '{dtt_pkg::RATIO_800, dtt_pkg::RATIO_1066, dtt_pkg::RATIO_1333};
    for (int i = 0; i < 3; i++) begin
      max_r = enc[i];
      req_r = enc[(i+1)%3];
      wait_cyc(2);
      cfg_rd(8'h50, {3'h0, enc[i], 19'h0, enc[(i+1)%3]}, "ratio");
      check("module clock", {27'h0, enc[(i+1)%3] >> 1}, {27'h0, mclk});
    end
    $display("test ratio done");
  endtask : t_ratio

  task automatic t_lock;
    cfg_wr(8'h9C, 32'h0000_0001);
    cfg_rd(8'h9C, 32'h0000_0001, "locked");
    cfg_wr(8'h9C, 32'h0000_000E);
    cfg_rd(8'h9C, 32'h0000_0001, "lock holds");
    do_reset();
    cfg_rd(8'h9C, 32'h0000_0000, "lock cleared");
    $display("test lock done");
  endtask : t_lock

  // ==========================================================================
  // Verdict, main sequence and watchdog
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial begin
    #2;
    do_reset();
    t_reset();
    t_throttle();
    t_pin();
    t_ignore();
    t_ratio();
    t_lock();
    summarize();
  end

  // Tests need some 130 cycles; over twenty times that means a hang
  initial begin
    #(3000 * 25);
    errors++;
    summarize();
  end
endmodule : testbench

`default_nettype wire
